// ==== inc/scd_cfg.svh ====
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// control byte field positions, as they sit in the byte sent msb first
`define SCD_CTRL_BCAST   7
`define SCD_CTRL_RW      6
`define SCD_CTRL_REG     5

// bit index of the last bit of a byte
`define SCD_BYTE_LAST    3'h7
// used part of the address byte
`define SCD_ADDR_MSB     6

// index decrement seen per channel and per device
`define SCD_CID_DEC_CH   4'h1
`define SCD_CID_DEC_DEV  4'h2

// reset values
`define SCD_RST_BIT      1'b0
`define SCD_RST_CS       1'b1
`define SCD_RST_SCLK     1'b1
`define SCD_RST_BORROW   1'b1

`endif

// ==== inc/scd_pkg.sv ====
package scd_pkg;

	// byte position inside one transfer, gray along the usual path
	typedef enum logic [1:0] {
		SCD_PH_CTRL  = 2'h0,
		SCD_PH_ADDR  = 2'h1,
		SCD_PH_DATA  = 2'h3,
		SCD_PH_DATA2 = 2'h2
	} scd_phase_t;

	typedef logic [15:0] scd_word_t;

endpackage

// ==== rtl/scd_spi_port.sv ====
// Behaviour
// R1: each channel forwards control byte with index decremented, lsb first.
// R2: broadcast, read/write and space-select bits pass down unchanged.
// R3: two channels in series inside the device, index drops by two.
// R4: only the channel seeing index zero acts and answers.
// R5: broadcast set: all bits forwarded unchanged, every channel applies the write.
// R6: 8-bit master register access is control, address, one data byte.
// R7: 8-bit master toggles chip select between bytes to end after one data byte.
// R8: serial input ignored during the data bytes of a read.
// R9: 16-bit master register access is four bytes in two words.
// R10: chip select held after eighth data bit means eight more clocks follow.
// R11: 16-bit register write discards the last eight bits.
// R12: 16-bit register read shifts the same byte out twice.
// R13: register read loads the shift register when the address byte completes.
// R14: register write updates the register only after the full data byte.
// R15: ram accesses always take four bytes.
// R16: ram read shifts out the channel data buffer from the previous request.
// R17: ram read end copies address to channel buffer and logs a pending read.
// R18: pending requests served in service windows; pending flag shows outstanding.
// R19: channel raises ram interrupt, if enabled, when its request is served.
// R20: ram write moves address and data to channel buffers, logs pending write.
// R21: buffers and pending flags are per channel and independent.
// R22: four-bit index sits in low control bits, sent lsb first.
// R23: master sets broadcast only for writes.
// R24: chip select change off a byte boundary returns the engine to idle.
// R25: only the seven low address bits are used.
// R26: sample input on rising clock, drive output on falling, msb first.
// R27: non-target channel keeps serial output released for the whole transaction.
`timescale 1ns/10ps
`include "scd_cfg.svh"

module scd_spi_port #(
	parameter int REG_DEPTH = 128
) (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   ce,
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   sdi,
	output logic                        sdo,
	output logic                        sdo_oe,
	output logic                        serial_through_out,
	input  wire logic                   ram_window,
	input  wire logic [1:0]             ram_int_en,
	input  wire logic [1:0][15:0]       ram_rdata,
	output logic      [1:0]             ram_req,
	output logic      [1:0]             ram_we,
	output logic      [1:0][6:0]        ram_addr,
	output logic      [1:0][15:0]       ram_wdata,
	output logic      [1:0]             ram_pending_flag,
	output logic      [1:0]             ram_int
);

	// serial decrement of one index bit while a borrow is pending
	function automatic logic scd_dec(input logic in_bit, input logic borrow, input logic act);
		scd_dec = in_bit ^ (borrow & act);
	endfunction

	logic                 rst_s1_q, rst_n_q;
	logic                 sclk_s1_q, sclk_s2_q, sclk_p_q;
	logic                 cs_s1_q, cs_s2_q, cs_p_q;
	logic                 sdi_s1_q, sdi_s2_q;
	scd_pkg::scd_phase_t  phase_q;
	logic [2:0]           bit_q;
	logic [7:0]           rx_q;
	logic                 bc_q, ctrl_rw_q, ctrl_reg_q;
	logic [6:0]           addr_q;
	scd_pkg::scd_word_t   data_q, shift_q;
	logic                 borrow0_q, borrow1_q, zero0_q, zero1_q;
	logic                 sdo_q, sdo_oe_q, through_q;
	logic [7:0]           reg_file_q [2][REG_DEPTH];
	logic [1:0]           req_q, wr_q, pend_q, int_q;
	logic [1:0][6:0]      abuf_q;
	logic [1:0][15:0]     dbuf_q;

	// reset release through two flops; the rest of the block uses rst_n_q
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= `SCD_RST_BIT;
			rst_n_q  <= `SCD_RST_BIT;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// pin synchronisers; only the second stage and the edge flop are read
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			// link clock idles high; resetting low would fake a rise after reset
			sclk_s1_q <= `SCD_RST_SCLK;
			sclk_s2_q <= `SCD_RST_SCLK;
			sclk_p_q  <= `SCD_RST_SCLK;
			cs_s1_q   <= `SCD_RST_CS;
			cs_s2_q   <= `SCD_RST_CS;
			cs_p_q    <= `SCD_RST_CS;
			sdi_s1_q  <= `SCD_RST_BIT;
			sdi_s2_q  <= `SCD_RST_BIT;
		end else if (ce) begin
			sclk_s1_q <= sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_p_q  <= sclk_s2_q;
			cs_s1_q   <= cs_n;
			cs_s2_q   <= cs_s1_q;
			cs_p_q    <= cs_s2_q;
			sdi_s1_q  <= sdi;
			sdi_s2_q  <= sdi_s1_q;
		end
	end

	// link events; clock edges qualified by chip select, select edges unqualified
	logic       cs_act, sclk_rise, sclk_fall, cs_edge, cs_rise, byte_end;
	logic       cid_win, dec_act, ch0_out, ch1_out;
	logic       addr_end, data_end, data2_end, reg_done, soft_rst;
	logic       rd_ch, rd_ok, reg_we, oe_d;
	logic [1:0] tgt;
	logic [7:0] rx_next, reg_val;
	logic [1:0] log_req;
	scd_pkg::scd_word_t load_val;

	assign cs_act    = !cs_s2_q;
	assign sclk_rise = sclk_s2_q && !sclk_p_q && cs_act;                  // R26
	assign sclk_fall = !sclk_s2_q && sclk_p_q && cs_act;                  // R26
	assign cs_edge   = cs_s2_q != cs_p_q;
	assign cs_rise   = cs_s2_q && !cs_p_q;
	assign byte_end  = sclk_rise && bit_q == `SCD_BYTE_LAST;
	assign rx_next   = {rx_q[6:0], sdi_s2_q};

	// index bits are the low nibble, so the second half of the control byte
	assign cid_win = phase_q == scd_pkg::SCD_PH_CTRL && bit_q[2];        // R22
	assign dec_act = cid_win && !bc_q;                                     // R5
	assign ch0_out = scd_dec(sdi_s2_q, borrow0_q, dec_act);                // R1
	assign ch1_out = scd_dec(ch0_out, borrow1_q, dec_act);                 // R3

	// byte completions and transfer ends
	assign addr_end  = byte_end && phase_q == scd_pkg::SCD_PH_ADDR;
	assign data_end  = byte_end && phase_q == scd_pkg::SCD_PH_DATA;
	assign data2_end = byte_end && phase_q == scd_pkg::SCD_PH_DATA2;
	assign soft_rst  = cs_edge && bit_q != 3'h0;                           // R24
	// an 8-bit master lifts chip select after the single data byte
	assign reg_done  = cs_rise && ctrl_reg_q && phase_q == scd_pkg::SCD_PH_DATA2; // R6

	// target selection; broadcast reads are never answered to avoid contention
	assign tgt    = bc_q ? 2'h3 : {zero1_q, zero0_q};                     // R4
	assign rd_ch  = zero1_q;
	assign rd_ok  = ctrl_rw_q && !bc_q && (zero0_q || zero1_q);            // R27
	assign reg_val = reg_file_q[rd_ch][rx_next[`SCD_ADDR_MSB:0]];          // R25
	assign load_val = ctrl_reg_q ? {reg_val, reg_val} : dbuf_q[rd_ch];     // R12
	assign reg_we = data_end && ctrl_reg_q && !ctrl_rw_q;                  // R14
	assign log_req = (data2_end && !ctrl_reg_q) ? tgt : 2'h0;              // R15
	assign oe_d   = cs_act && rd_ok && phase_q[1];

	// byte framing; chip select edges win over a coincident clock edge
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			phase_q <= scd_pkg::SCD_PH_CTRL;
			bit_q   <= 3'h0;
			rx_q    <= 8'h00;
		end else if (ce) begin
			if (soft_rst || reg_done) begin                                // R24
				phase_q <= scd_pkg::SCD_PH_CTRL;
				bit_q   <= 3'h0;
			end else if (sclk_rise) begin
				rx_q  <= rx_next;
				bit_q <= bit_q + 3'h1;
				if (byte_end) begin
					unique case (phase_q)
						scd_pkg::SCD_PH_CTRL:  phase_q <= scd_pkg::SCD_PH_ADDR;
						scd_pkg::SCD_PH_ADDR:  phase_q <= scd_pkg::SCD_PH_DATA;
						scd_pkg::SCD_PH_DATA:  phase_q <= scd_pkg::SCD_PH_DATA2; // R10
						scd_pkg::SCD_PH_DATA2: phase_q <= scd_pkg::SCD_PH_CTRL;  // R9
					endcase
				end
			end
		end
	end

	// control fields, address and write data capture
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bc_q       <= `SCD_RST_BIT;
			ctrl_rw_q  <= `SCD_RST_BIT;
			ctrl_reg_q <= `SCD_RST_BIT;
			addr_q     <= 7'h00;
			data_q     <= 16'h0000;
		end else if (ce && sclk_rise && !soft_rst) begin
			if (phase_q == scd_pkg::SCD_PH_CTRL && bit_q == 3'h0)
				bc_q <= sdi_s2_q;
			if (byte_end && phase_q == scd_pkg::SCD_PH_CTRL) begin
				ctrl_rw_q  <= rx_next[`SCD_CTRL_RW];
				ctrl_reg_q <= rx_next[`SCD_CTRL_REG];
			end
			if (addr_end)
				addr_q <= rx_next[`SCD_ADDR_MSB:0];                     // R25
			// a read never samples the data bytes
			if (data_end && !ctrl_rw_q)                                    // R8
				data_q[15:8] <= rx_next;
			if (data2_end && !ctrl_rw_q)                                   // R11
				data_q[7:0] <= rx_next;
		end
	end

	// per channel index decrement and zero detection, restarted on each control byte
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			borrow0_q <= `SCD_RST_BORROW;
			borrow1_q <= `SCD_RST_BORROW;
			zero0_q   <= `SCD_RST_BIT;
			zero1_q   <= `SCD_RST_BIT;
		end else if (ce && sclk_rise && !soft_rst) begin
			if (phase_q == scd_pkg::SCD_PH_CTRL && bit_q == 3'h0) begin
				borrow0_q <= `SCD_RST_BORROW;
				borrow1_q <= `SCD_RST_BORROW;
				zero0_q   <= 1'b1;
				zero1_q   <= 1'b1;
			end else if (cid_win) begin
				borrow0_q <= borrow0_q & ~sdi_s2_q;                      // R1
				borrow1_q <= borrow1_q & ~ch0_out;                       // R3
				zero0_q   <= zero0_q & ~sdi_s2_q;                        // R4
				zero1_q   <= zero1_q & ~ch0_out;                         // R4
			end
		end
	end

	// through output follows the second channel every cycle, so it trails sdi
	// by the two synchroniser stages and the output flop, well inside half a link clock period
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q)
			through_q <= `SCD_RST_BIT;
		else if (ce)
			through_q <= ch1_out;                                          // R2
	end

	// read shift register: load at address end, shift on falling edges
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			shift_q  <= 16'h0000;
			sdo_q    <= `SCD_RST_BIT;
			sdo_oe_q <= `SCD_RST_BIT;
		end else if (ce) begin
			sdo_oe_q <= oe_d;                                              // R27
			if (addr_end && ctrl_rw_q && !soft_rst)
				shift_q <= load_val;                                       // R13
			else if (sclk_fall) begin
				sdo_q   <= shift_q[15];                                    // R26
				shift_q <= {shift_q[14:0], 1'b0};
			end
		end
	end

	// register file, written by every targeted channel after the data byte
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int c = 0; c < 2; c++)
				for (int a = 0; a < REG_DEPTH; a++)
					reg_file_q[c][a] <= 8'h00;
		end else if (ce && reg_we) begin
			for (int c = 0; c < 2; c++)
				if (tgt[c])
					reg_file_q[c][addr_q] <= rx_next;                  // R5
		end
	end

	// ram request buffers per channel; a new request beats a completing one
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			req_q  <= 2'h0;
			wr_q   <= 2'h0;
			pend_q <= 2'h0;
			int_q  <= 2'h0;
			abuf_q <= '0;
			dbuf_q <= '0;
		end else if (ce) begin
			for (int c = 0; c < 2; c++) begin                              // R21
				req_q[c] <= ram_window && pend_q[c] && !req_q[c] && !log_req[c]; // R18
				int_q[c] <= req_q[c] && ram_int_en[c];                     // R19
				if (log_req[c]) begin
					abuf_q[c] <= addr_q;                                   // R17
					wr_q[c]   <= !ctrl_rw_q;
					pend_q[c] <= 1'b1;
					if (!ctrl_rw_q)
						dbuf_q[c] <= {data_q[15:8], rx_next};              // R20
				end else if (req_q[c]) begin
					pend_q[c] <= 1'b0;
					if (!wr_q[c])
						dbuf_q[c] <= ram_rdata[c];                         // R16
				end
			end
		end
	end

	assign sdo                = sdo_q;
	assign sdo_oe             = sdo_oe_q;
	assign serial_through_out = through_q;
	assign ram_req            = req_q;
	assign ram_we             = wr_q;
	assign ram_addr           = abuf_q;
	assign ram_wdata          = dbuf_q;
	assign ram_pending_flag   = pend_q;
	assign ram_int            = int_q;

	// checking helpers: index as received and as forwarded, lsb first
	logic [3:0] rx_cid_h, ch0_cid_h, thr_cid_h;
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_cid_h  <= 4'h0;
			ch0_cid_h <= 4'h0;
			thr_cid_h <= 4'h0;
		end else if (ce && sclk_rise && cid_win) begin
			rx_cid_h  <= {sdi_s2_q, rx_cid_h[3:1]};
			ch0_cid_h <= {ch0_out, ch0_cid_h[3:1]};
			thr_cid_h <= {through_q, thr_cid_h[3:1]};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	logic cid_last;
	assign cid_last = ce && sclk_rise && cid_win && bit_q == `SCD_BYTE_LAST && !soft_rst;

	a_ch0_decrement: assert property (cid_last && !bc_q |=> // R1
		ch0_cid_h == rx_cid_h - `SCD_CID_DEC_CH) else $error("channel index not decremented");
	a_dev_decrement: assert property (cid_last && !bc_q |=> // R3
		thr_cid_h == rx_cid_h - `SCD_CID_DEC_DEV) else $error("device index drop wrong");
	a_bcast_passes: assert property (cid_last && bc_q |=> // R5
		thr_cid_h == rx_cid_h) else $error("broadcast index modified");
	a_flags_pass: assert property (ce && phase_q == scd_pkg::SCD_PH_CTRL && !bit_q[2] |=> // R2
		serial_through_out == $past(sdi_s2_q)) else $error("control flag altered");
	a_answer_target: assert property (sdo_oe |-> // R4
		(zero0_q ^ zero1_q) && !bc_q) else $error("non-target channel answers");
	a_oe_read_only: assert property (sdo_oe |-> // R27
		$past(ctrl_rw_q && phase_q[1] && cs_act)) else $error("output driven outside read data");
	a_reg_write_time: assert property (ce && reg_we && tgt[0] |=> // R14
		reg_file_q[0][addr_q] == $past(rx_next)) else $error("register write lost");
	a_reg_repeat: assert property (ce && addr_end && ctrl_rw_q && ctrl_reg_q && !soft_rst |=> // R12
		shift_q[15:8] == shift_q[7:0]) else $error("read byte not repeated");
	a_soft_reset: assert property (ce && cs_edge && bit_q != 3'h0 |=> // R24
		phase_q == scd_pkg::SCD_PH_CTRL && bit_q == 3'h0) else $error("no soft reset");
	a_ram_logged: assert property (ce && log_req[0] |=> // R17
		ram_pending_flag[0] && ram_addr[0] == $past(addr_q)) else $error("ram request lost");
	a_pend_holds: assert property (ce && ram_pending_flag[1] && !ram_req[1] |=> // R18
		ram_pending_flag[1]) else $error("pending flag dropped unserved");
	a_ram_irq: assert property (ram_int[0] |-> // R19
		$past(ram_req[0] && ram_int_en[0])) else $error("spurious ram interrupt");
	a_read_ignores: assert property (ce && ctrl_rw_q && phase_q[1] |=> // R8
		$stable(data_q)) else $error("read data bytes sampled");

	c_reg_write8: cover property (ce && reg_done && !ctrl_rw_q);
	c_reg_read16: cover property (ce && data2_end && ctrl_reg_q && ctrl_rw_q);
	c_ram_served: cover property (ram_req[0] && !ram_we[0] ##1 ram_int[0]);
	c_bcast_write: cover property (ce && reg_we && bc_q);

endmodule

// ==== tb/scd_spi_master.sv ====
`timescale 1ns/10ps
// behavioural link master; sclk idles high and only runs inside frames
module scd_spi_master (
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo_line,
	input  wire logic thru
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end

	// one access of nb bits, msb first, sdo taken on each rise, through data on the first eight
	// an 8-bit master lifts the select between bytes, a 16-bit one keeps it low
	task automatic xfer(input logic w16, input int nb, input logic [31:0] tx,
		output logic [31:0] rx, output logic [7:0] tr);
		rx = '0;
		tr = '0;
		cs_n = 1'b0;
		// odd start offset keeps every later link edge off the bench clock edges
		#61;
		for (int b = 0; b < nb; b++) begin
			if (b > 0 && b % 8 == 0 && !w16) begin
				#30;
				cs_n = 1'b1;
				#100;
				cs_n = 1'b0;
				#60;
			end
			sclk = 1'b0;
			sdi  = tx[31 - b];
			#62.5;
			sclk = 1'b1;
			rx[31 - b] = sdo_line;
			if (b < 8)
				tr[7 - b] = thru;
			#62.5;
		end
		#30;
		cs_n = 1'b1;
		// released line shows the inverse so a stale level is never trusted
		sdi = ~sdi;
		#250;
	endtask
endmodule

// ==== tb/scd_spi_port_tb_top.sv ====
`timescale 1ns/10ps
module scd_spi_port_tb_top;
	logic                  clk, reset_n, ce, ram_window, oe_seen, oe_clr;
	logic [1:0]            ram_int_en;
	logic [1:0][15:0]      ram_rdata;
	logic [31:0]           rx;
	int                    errors, n_checks;
	logic [3:0]            cids [5] = '{4'h2, 4'h3, 4'hf, 4'h0, 4'h1};
	wire logic             sclk, cs_n, sdi, sdo, sdo_oe, thru;
	wire logic [1:0]       ram_req, ram_we, ram_pending_flag, ram_int;
	wire logic [1:0][6:0]  ram_addr;
	wire logic [1:0][15:0] ram_wdata;
	// board pull-down: a released sdo reads low
	wire logic             sdo_line = sdo_oe ? sdo : 1'b0;

	scd_spi_port scd_spi_port_i (.clk(clk), .reset_n(reset_n), .ce(ce), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .serial_through_out(thru),
		.ram_window(ram_window), .ram_int_en(ram_int_en), .ram_rdata(ram_rdata),
		.ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_pending_flag(ram_pending_flag), .ram_int(ram_int));
	scd_spi_master scd_spi_master_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo_line(sdo_line), .thru(thru));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// any drive of sdo is remembered until a test clears it
	always @(posedge clk) begin
		if (oe_clr)
			oe_seen <= 1'b0;
		else if (sdo_oe === 1'b1)
			oe_seen <= 1'b1;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [3:0] rev4(input logic [3:0] v);
		return {v[0], v[1], v[2], v[3]};
	endfunction
	// kind is broadcast, read, register; the index goes out lsb first
	function automatic logic [7:0] ctl(input logic [2:0] k, input logic [3:0] channel_index);
		return {k, 1'b0, rev4(channel_index)};
	endfunction
	// whole access; the forwarded control byte must drop the index by two, or pass unchanged on broadcast
	task automatic acc(input logic w16, input int nb, input logic [7:0] c, a,
		input logic [15:0] d);
		logic [7:0] tr;
		@(negedge clk);
		scd_spi_master_i.xfer(w16, nb, {c, a, d}, rx, tr);
		if (nb >= 8)
			chk(tr, c[7] ? c : {c[7:4], rev4(rev4(c[3:0]) - 4'h2)});
	endtask
	task automatic rd16(input logic [3:0] channel_index, input logic [7:0] a, e);
		acc(1'b1, 32, ctl(3'b011, channel_index), a, 16'h5aa5);
		chk(rx[15:0], {e, e});
	endtask
	// service window: request one cycle later, done and interrupt the cycle after
	task automatic svc(input logic [1:0] m, we, input logic [1:0][6:0] a,
		input logic [1:0][15:0] d);
		@(negedge clk) ram_window = 1'b1;
		@(negedge clk) ram_window = 1'b0;
		chk(ram_req, m);
		for (int c = 0; c < 2; c++) begin
			if (m[c]) begin
				chk(ram_we[c], we[c]);
				chk(ram_addr[c], a[c]);
				if (we[c])
					chk(ram_wdata[c], d[c]);
			end
		end
		@(negedge clk);
		chk(ram_pending_flag & m, 2'h0);
		chk(ram_int, m & ram_int_en);
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		stop_test;
	end

	initial begin
		ce = 1'b1;
		reset_n = 1'b0;
		ram_window = 1'b0;
		ram_int_en = 2'b01;
		ram_rdata = '0;
		oe_clr = 1'b1;
		errors = 0;
		n_checks = 0;
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		oe_clr = 1'b0;
		repeat (10) @(negedge clk);
		// only indices 0 and 1 belong to this device
		foreach (cids[i]) acc(1'b0, 24, ctl(3'b001, cids[i]), 8'h10, {4'h4, cids[i], 8'h00});
		rd16(4'h0, 8'h10, 8'h40);
		rd16(4'h1, 8'h10, 8'h41);
		@(negedge clk) oe_clr = 1'b1;
		@(negedge clk) oe_clr = 1'b0;
		rd16(4'h2, 8'h10, 8'h00);
		chk(oe_seen, 1'b0);
		$display("test chain done");
		// 16-bit write with a junk tail and address bit 7 set
		acc(1'b1, 32, ctl(3'b001, 4'h0), 8'h91, 16'h3cee);
		acc(1'b0, 24, ctl(3'b011, 4'h0), 8'h11, 16'hff00);
		chk(rx[15:8], 8'h3c);
		acc(1'b0, 24, ctl(3'b101, 4'h9), 8'h20, 16'h7700);
		rd16(4'h0, 8'h20, 8'h77);
		rd16(4'h1, 8'h20, 8'h77);
		$display("test width done");
		// select lifted off a byte boundary: nothing written, engine resyncs
		acc(1'b1, 20, ctl(3'b001, 4'h0), 8'h11, 16'h9900);
		acc(1'b1, 3, 8'hff, 8'h00, 16'h0000);
		rd16(4'h0, 8'h11, 8'h3c);
		$display("test abort done");
		// ram writes to both channels outstanding together
		acc(1'b1, 32, ctl(3'b000, 4'h0), 8'h12, 16'h1234);
		acc(1'b0, 32, ctl(3'b000, 4'h1), 8'hb4, 16'habcd);
		chk(ram_pending_flag, 2'h3);
		svc(2'h3, 2'h3, {7'h34, 7'h12}, {16'habcd, 16'h1234});
		// ram read hands back the previous buffer, new result on the next read
		acc(1'b1, 32, ctl(3'b010, 4'h0), 8'h56, 16'h5aa5);
		chk(rx[15:0], 16'h1234);
		chk(ram_pending_flag, 2'h1);
		@(negedge clk) ram_rdata[0] = 16'hbeef;
		svc(2'h1, 2'h0, {7'h00, 7'h56}, '0);
		acc(1'b0, 32, ctl(3'b010, 4'h0), 8'h00, 16'h5aa5);
		chk(rx[15:0], 16'hbeef);
		$display("test ram done");
		stop_test;
	end
endmodule
